// File: hw/gpx_top.sv
// GPIO ports with per-port modes and shared pin interrupts.
// Assumes an APB master on pclk and asynchronous pins.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module gpx_top
   import gpx_pkg::*;
(
   // Clock and reset
   input  logic            pclk,
   input  logic            presetn,
   // APB slave
   input  logic            psel,
   input  logic            penable,
   input  logic            pwrite,
   input  logic [7:0]      paddr,
   input  logic [31:0]     pwdata,
   output logic [31:0]     prdata,
   output logic            pready,
   output logic            pslverr,
   // General-purpose pins
   input  logic [NGP-1:0]  gp_in,
   output logic [NGP-1:0]  gp_out,
   output logic [NGP-1:0]  gp_oe_n,
   output logic [NGP-1:0]  gp_pu,
   // High-current pins
   input  logic [NHC-1:0]  hc_in,
   output logic [NHC-1:0]  hc_out,
   output logic [NHC-1:0]  hc_oe_n,
   // Interrupt requests
   output logic            gp_irq,
   output logic            hc_irq
);

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [7:0]     cfg;
      logic [NGP-1:0] data;
      logic [NGP-1:0] ie;
      logic [NHC-1:0] hc_data;
      logic [NHC-1:0] hc_ie;
      logic [NHC-1:0] hc_pol;
      logic [31:0]    prdata;
      logic [NGP-1:0] gp_out;
      logic [NGP-1:0] gp_oe_n;
      logic [NGP-1:0] gp_pu;
      logic [NHC-1:0] hc_out;
      logic [NHC-1:0] hc_oe_n;
   } gpx_top_state_type;

   localparam gpx_top_state_type ST_RESET = '{
      cfg:     CFG_RESET,
      data:    {NPORT{DATA_RESET}},
      ie:      {NPORT{IE_RESET}},
      hc_data: DATA_RESET,
      hc_ie:   IE_RESET,
      hc_pol:  POL_RESET,
      prdata:  32'h0000_0000,
      gp_out:  '0,
      gp_oe_n: '1,
      gp_pu:   '0,
      hc_out:  '0,
      hc_oe_n: '1
   };

   gpx_top_state_type st_reg;
   gpx_top_state_type st_next;

   logic [NGP-1:0] gp_lvl;
   logic [NGP-1:0] gp_rise;
   logic [NGP-1:0] gp_fall;
   logic [NHC-1:0] hc_lvl;
   logic [NHC-1:0] hc_rise;
   logic [NHC-1:0] hc_fall;
   logic           wr_acc;
   logic           rd_setup;

   gpx_evt_if #(.N(NGP)) gp_ev ();
   gpx_evt_if #(.N(NHC)) hc_ev ();

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [7:0] port_ofs(input logic [7:0] base,
                                          input int p);
      port_ofs = base + OFS_STRIDE * 8'(p);
   endfunction

   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == OFS_CFG) || (a == OFS_HC_DATA) ||
                  (a == OFS_HC_IE) || (a == OFS_HC_POL);
      for (int p = 0; p < NPORT; p++)
         if (a == port_ofs(OFS_DATA0, p) || a == port_ofs(OFS_IE0, p))
            is_mapped = 1'b1;
   endfunction

   function automatic gpx_mode_type pin_mode(input logic [7:0] cfg,
                                            input int i);
      pin_mode = gpx_decode(cfg[CFG_W*(i/PW) +: CFG_W]);
   endfunction

   // ****************************************
   // Pin synchronisers
   // ****************************************
   gpx_sync_edge #(.N(NGP)) u_gp_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     (gp_in),
      .lvl     (gp_lvl),
      .rise    (gp_rise),
      .fall    (gp_fall)
   );

   gpx_sync_edge #(.N(NHC)) u_hc_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     (hc_in),
      .lvl     (hc_lvl),
      .rise    (hc_rise),
      .fall    (hc_fall)
   );

   // ****************************************
   // Trigger qualification
   // ****************************************
   always_comb
   begin
      for (int i = 0; i < NGP; i++)
      begin
         unique case (pin_mode(st_reg.cfg, i))
            MODE_PULLUP, MODE_OD_FALL:
            begin
               gp_ev.trig[i] = st_reg.ie[i] & gp_fall[i];
               gp_ev.hold[i] = ~gp_lvl[i];
               gp_ev.arm[i]  = st_reg.ie[i];
            end
            MODE_CMOS:
            begin
               gp_ev.trig[i] = 1'b0;
               gp_ev.hold[i] = 1'b0;
               gp_ev.arm[i]  = 1'b0;
            end
            default:
            begin
               gp_ev.trig[i] = st_reg.ie[i] & gp_rise[i];
               gp_ev.hold[i] = gp_lvl[i];
               gp_ev.arm[i]  = st_reg.ie[i];
            end
         endcase
      end
   end

   always_comb
   begin
      hc_ev.trig = st_reg.hc_ie &
                   ((st_reg.hc_pol & hc_rise) | (~st_reg.hc_pol & hc_fall));
      hc_ev.hold = ~(hc_lvl ^ st_reg.hc_pol);
      hc_ev.arm  = st_reg.hc_ie;
   end

   // ****************************************
   // Interrupt merging
   // ****************************************
   // every enabled pin not in driven mode feeds the merger
   gpx_irq_merge #(.N(NGP)) u_gp_merge (
      .pclk    (pclk),
      .presetn (presetn),
      .ev      (gp_ev.mrg)
   );

   gpx_irq_merge #(.N(NHC)) u_hc_merge (
      .pclk    (pclk),
      .presetn (presetn),
      .ev      (hc_ev.mrg)
   );

   // ****************************************
   // Registers and pin drive
   // ****************************************
   assign wr_acc   = psel & penable & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;

   always_comb
   begin
      st_next = st_reg;
      if (wr_acc)
      begin
         if (paddr == OFS_CFG)
            st_next.cfg = pwdata[7:0];
         if (paddr == OFS_HC_DATA)
            st_next.hc_data = pwdata[NHC-1:0];
         if (paddr == OFS_HC_IE)
            st_next.hc_ie = pwdata[NHC-1:0];
         if (paddr == OFS_HC_POL)
            st_next.hc_pol = pwdata[NHC-1:0];
         for (int p = 0; p < NPORT; p++)
         begin
            if (paddr == port_ofs(OFS_DATA0, p))
               st_next.data[p*PW +: PW] = pwdata[PW-1:0];
            if (paddr == port_ofs(OFS_IE0, p))
               st_next.ie[p*PW +: PW] = pwdata[PW-1:0];
         end
      end
      // Read data captured in setup, so no wait state
      if (rd_setup)
      begin
         st_next.prdata = 32'h0000_0000;
         if (paddr == OFS_HC_DATA)
            st_next.prdata[NHC-1:0] = hc_lvl;
         for (int p = 0; p < NPORT; p++)
            if (paddr == port_ofs(OFS_DATA0, p))
               st_next.prdata[PW-1:0] = gp_lvl[p*PW +: PW];
      end
      for (int i = 0; i < NGP; i++)
      begin
         st_next.gp_out[i]  = 1'b0;
         st_next.gp_oe_n[i] = st_reg.data[i];
         st_next.gp_pu[i]   = 1'b0;
         unique case (pin_mode(st_reg.cfg, i))
            // pull-up on 1, drive low on 0
            MODE_PULLUP:
               st_next.gp_pu[i] = st_reg.data[i];
            // enable bit picks output or open-drain
            MODE_CMOS:
               if (!st_reg.ie[i])
               begin
                  st_next.gp_out[i]  = st_reg.data[i];
                  st_next.gp_oe_n[i] = 1'b0;
               end
            default:
               st_next.gp_pu[i] = 1'b0;
         endcase
      end
      st_next.hc_out  = '0;
      st_next.hc_oe_n = st_reg.hc_data;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         st_reg <= ST_RESET;
      else
         st_reg <= st_next;
   end

   assign prdata  = st_reg.prdata;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~is_mapped(paddr);
   assign gp_out  = st_reg.gp_out;
   assign gp_oe_n = st_reg.gp_oe_n;
   assign gp_pu   = st_reg.gp_pu;
   assign hc_out  = st_reg.hc_out;
   assign hc_oe_n = st_reg.hc_oe_n;
   assign gp_irq  = gp_ev.irq;
   assign hc_irq  = hc_ev.irq;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_cfg_hold: assert property (!(wr_acc && paddr == OFS_CFG) |=> $stable(st_reg.cfg))
      else $error("config changed without a write");
   a_hc_en_hold: assert property (!(wr_acc && paddr == OFS_HC_IE) |=> $stable(st_reg.hc_ie))
      else $error("high-current enables changed without a write");
   a_en_keep: assert property ((gp_irq && !wr_acc) |=> $stable(st_reg.ie))
      else $error("port enables changed on request");
   a_hc_pol: assert property ((hc_ev.trig & ~hc_rise & st_reg.hc_pol) == '0)
      else $error("rising-polarity pin fired without rising edge");

   // ****************************************
   // Register, source, edge and pin drive checks
   // ****************************************
   // config write stored
   a_cfg_write: assert property ((wr_acc && paddr == OFS_CFG) |=>
      st_reg.cfg == $past(pwdata[7:0]))
      else $error("config write not stored");
   a_wo_read: assert property ((rd_setup && paddr == OFS_CFG) |=>
      prdata == 32'h0000_0000)
      else $error("write-only register read nonzero");
   a_ie_write: assert property ((wr_acc && paddr == OFS_IE0) |=>
      st_reg.ie[PW-1:0] == $past(pwdata[PW-1:0]))
      else $error("enable write not stored");
   a_en_gate: assert property ((gp_ev.trig & ~st_reg.ie) == '0)
      else $error("disabled pin raised a trigger");
   a_hc_gate: assert property ((hc_ev.trig & ~st_reg.hc_ie) == '0)
      else $error("disabled high-current pin raised a trigger");
   a_hc_fall: assert property (
      (hc_ev.trig & ~hc_fall & ~st_reg.hc_pol) == '0)
      else $error("high-current pin fired without falling edge");
   a_gp_src: assert property (gp_irq |-> $past(gp_ev.trig) != '0)
      else $error("shared request without a pin trigger");
   a_hc_src: assert property (hc_irq |-> $past(hc_ev.trig) != '0)
      else $error("high-current request without a pin trigger");

   for (genvar g = 0; g < NGP; g++)
   begin : g_chk
      a_pullup_drive: assert property ((pin_mode(st_reg.cfg, g) == MODE_PULLUP && !st_reg.data[g]) |=> (!gp_oe_n[g] && !gp_out[g] && !gp_pu[g]))
         else $error("pull-up pin written 0 not driven low");
      a_pullup_float: assert property ((pin_mode(st_reg.cfg, g) == MODE_PULLUP && st_reg.data[g]) |=> (gp_oe_n[g] && gp_pu[g]))
         else $error("pull-up pin written 1 not pulled up");
      a_cmos_quiet: assert property ((pin_mode(st_reg.cfg, g) == MODE_CMOS) |-> !gp_ev.trig[g])
         else $error("driven-mode pin raised a trigger");
      a_cmos_dir: assert property ((pin_mode(st_reg.cfg, g) == MODE_CMOS && !st_reg.ie[g]) |=> (!gp_oe_n[g] && gp_out[g] == $past(st_reg.data[g])))
         else $error("driven output pin not driving its data");
      a_od_float: assert property ((pin_mode(st_reg.cfg, g) >= MODE_OD_RISE && pin_mode(st_reg.cfg, g) <= MODE_OD_FALL && st_reg.data[g]) |=> (gp_oe_n[g] && !gp_pu[g]))
         else $error("open-drain pin written 1 not floating");
      a_fall_edge: assert property ((gp_ev.trig[g] && pin_mode(st_reg.cfg, g) != MODE_OD_RISE) |-> gp_fall[g])
         else $error("falling-polarity pin fired without falling edge");
      a_rise_edge: assert property ((gp_ev.trig[g] && pin_mode(st_reg.cfg, g) == MODE_OD_RISE) |-> gp_rise[g])
         else $error("rising-polarity pin fired without rising edge");
      a_od_low: assert property ((pin_mode(st_reg.cfg, g) inside
         {MODE_OD_RISE, MODE_OD_FALL} && !st_reg.data[g]) |=>
         (!gp_oe_n[g] && !gp_out[g] && !gp_pu[g]))
         else $error("open-drain pin written 0 not driven low");
      a_cmos_od: assert property (
         (pin_mode(st_reg.cfg, g) == MODE_CMOS && st_reg.ie[g]) |=>
         (gp_oe_n[g] == $past(st_reg.data[g]) && !gp_out[g]))
         else $error("driven-mode input pin not open-drain");
      a_cmos_arm: assert property (
         (pin_mode(st_reg.cfg, g) == MODE_CMOS) |-> !gp_ev.arm[g])
         else $error("driven-mode pin armed for lockout");
   end

endmodule // gpx_top

// File: hw/gpx_pkg.sv
// GPIO port block constants, register map and mode decode.
// Assumes a 32-bit APB slave on pclk with byte addresses.
// Behaviour
// - Pull-up mode: data 1 pulls up, 0 drives low
// - Pull-up mode interrupts on falling edges
// - Driven mode: symmetric drive, never interrupts
// - Driven mode: enable bit selects output or open-drain
// - Open-drain: no pull-up, 1 floats, 0 low
// - Open-drain: rising or falling edge per config
// - Reset clears config: open-drain, rising edge
// - Write-only config, two bits per port
// - Every enabled pin not in driven mode can interrupt, port polarity
// - One shared request, source not indicated
// - Triggered pin locks out others until released
// - No pin priority, enables kept on acknowledge
// - High-current pins interrupt, polarity per pin
// - High-current pins share one request
// - High-current trigger locks out its other pins
// - No priority, high-current enables kept
// - Config codes: 11 pull-up, 10 driven, 01 falling
// - Enables clear at reset, 1 enables pin
package gpx_pkg;

   // ****************************************
   // Sizes
   // ****************************************
   localparam int NPORT = 4;
   localparam int PW    = 8;
   localparam int NGP   = 32;
   localparam int NHC   = 8;
   localparam int CFG_W = 2;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] OFS_CFG     = 8'h08;
   localparam logic [7:0] OFS_DATA0   = 8'h10;
   localparam logic [7:0] OFS_IE0     = 8'h20;
   localparam logic [7:0] OFS_STRIDE  = 8'h04;
   localparam logic [7:0] OFS_HC_DATA = 8'h30;
   localparam logic [7:0] OFS_HC_IE   = 8'h34;
   localparam logic [7:0] OFS_HC_POL  = 8'h38;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] CFG_RESET  = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'hFF;
   localparam logic [7:0] IE_RESET   = 8'h00;
   localparam logic [7:0] POL_RESET  = 8'h00;

   // ****************************************
   // Config encodings
   // ****************************************
   localparam logic [1:0] CFG_PULLUP  = 2'h3;
   localparam logic [1:0] CFG_CMOS    = 2'h2;
   localparam logic [1:0] CFG_OD_FALL = 2'h1;

   typedef enum logic [1:0] {
      MODE_OD_RISE,
      MODE_OD_FALL,
      MODE_CMOS,
      MODE_PULLUP
   } gpx_mode_type;

   function automatic gpx_mode_type gpx_decode(input logic [1:0] c);
      unique case (c)
         CFG_PULLUP:  gpx_decode = MODE_PULLUP;
         CFG_CMOS:    gpx_decode = MODE_CMOS;
         CFG_OD_FALL: gpx_decode = MODE_OD_FALL;
         default:     gpx_decode = MODE_OD_RISE;
      endcase
   endfunction

endpackage

// File: hw/gpx_evt_if.sv
// Pin event bundle between the port logic and an interrupt merger.
// Assumes both ends run on the same pclk.
`timescale 1ns/1ps
interface gpx_evt_if #(parameter int N = 8);
   logic [N-1:0] trig;
   logic [N-1:0] arm;
   logic [N-1:0] hold;
   logic         irq;
   logic         locked;
   modport src (output trig, arm, hold, input irq, locked);
   modport mrg (input trig, arm, hold, output irq, locked);
endinterface

// File: hw/gpx_sync_edge.sv
// Pin synchroniser with registered edge pulses.
// Assumes pins are asynchronous to pclk.
`timescale 1ns/1ps
module gpx_sync_edge
   import gpx_pkg::*;
#(
   parameter int N = 8
)(
   // Clock and reset
   input  logic         pclk,
   input  logic         presetn,
   // Pins
   input  logic [N-1:0] pin,
   // Synchronised level and edges
   output logic [N-1:0] lvl,
   output logic [N-1:0] rise,
   output logic [N-1:0] fall
);

   typedef struct packed {
      logic [N-1:0] s1;
      logic [N-1:0] s2;
      logic [N-1:0] s3;
      logic [N-1:0] rise;
      logic [N-1:0] fall;
      logic [2:0]   warm;
   } gpx_sync_state_type;

   gpx_sync_state_type st_reg;
   gpx_sync_state_type st_next;

   always_comb
   begin
      st_next      = st_reg;
      st_next.s1   = pin;
      st_next.s2   = st_reg.s1;
      st_next.s3   = st_reg.s2;
      // No edge until the pipe holds real pin levels
      st_next.warm = {st_reg.warm[1:0], 1'b1};
      st_next.rise = st_reg.s2 & ~st_reg.s3 & {N{st_reg.warm[2]}};
      st_next.fall = ~st_reg.s2 & st_reg.s3 & {N{st_reg.warm[2]}};
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign lvl  = st_reg.s3;
   assign rise = st_reg.rise;
   assign fall = st_reg.fall;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_rise_clean: assert property (|rise |-> (rise & ~$past(lvl)) == rise)
      else $error("rise pulse without low-to-high level");
   a_pulse_single: assert property (|(rise | fall) |=> ((rise & $past(rise)) | (fall & $past(fall))) == '0)
      else $error("edge pulse longer than one cycle");

endmodule // gpx_sync_edge

// File: hw/gpx_irq_merge.sv
// Merges pin triggers into one request with lockout.
// Assumes trig bits are one-cycle pulses already qualified.
`timescale 1ns/1ps
module gpx_irq_merge
   import gpx_pkg::*;
#(
   parameter int N = 8
)(
   // Clock and reset
   input  logic pclk,
   input  logic presetn,
   // Events
   gpx_evt_if.mrg ev
);

   localparam int IW = (N > 1) ? $clog2(N) : 1;

   typedef struct packed {
      logic          locked;
      logic [IW-1:0] idx;
      logic          irq;
   } gpx_merge_state_type;

   gpx_merge_state_type st_reg;
   gpx_merge_state_type st_next;
   logic                release_c;

   // Lowest index only picks which pin to watch
   function automatic logic [IW-1:0] first_set(input logic [N-1:0] v);
      first_set = '0;
      for (int i = N - 1; i >= 0; i--)
         if (v[i])
            first_set = IW'(i);
   endfunction

   always_comb
   begin
      st_next     = st_reg;
      st_next.irq = 1'b0;
      // release on level return or disable
      // same lockout serves the hc pins
      release_c = st_reg.locked &&
                  (!ev.hold[st_reg.idx] || !ev.arm[st_reg.idx]);
      if (release_c)
         st_next.locked = 1'b0;
      if ((!st_reg.locked || release_c) && (|ev.trig))
      begin
         st_next.locked = 1'b1;
         st_next.idx    = first_set(ev.trig);
         st_next.irq    = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign ev.irq    = st_reg.irq;
   assign ev.locked = st_reg.locked;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_fire;
      ev.irq ##0 ev.locked;
   endsequence

   sequence s_held;
      ev.locked && ev.hold[st_reg.idx] && ev.arm[st_reg.idx];
   endsequence

   a_irq_lock: assert property (s_fire ##0 !release_c |=> !ev.irq)
      else $error("request not single-cycle or lock missing");
   a_lock_block: assert property (s_held |=> !ev.irq)
      else $error("request raised while another pin holds lock");
   a_lock_free: assert property ((ev.locked && !ev.arm[st_reg.idx] && ev.trig == '0) |=> !ev.locked)
      else $error("lock not released after disable");
   a_trig_fire: assert property ((!ev.locked && |ev.trig) |=> s_fire)
      else $error("free trigger did not raise request");

endmodule // gpx_irq_merge

// File: testbench/gpx_pins_model.sv
// Board side of the GPIO pins: pull-ups plus bench-controlled drivers.
// Assumes the bench only drives pins that the device has released.
`timescale 1ns/1ps
module gpx_pins_model
   import gpx_pkg::*;
(
   // Device pin outputs
   input  logic [NGP-1:0] gp_out,
   input  logic [NGP-1:0] gp_oe_n,
   input  logic [NHC-1:0] hc_out,
   input  logic [NHC-1:0] hc_oe_n,
   // External drivers
   input  logic [NGP-1:0] gp_ext_en,
   input  logic [NGP-1:0] gp_ext_val,
   input  logic [NHC-1:0] hc_ext_en,
   input  logic [NHC-1:0] hc_ext_val,
   // Resolved levels
   output logic [NGP-1:0] gp_in,
   output logic [NHC-1:0] hc_in
);
   // ****************************************
   // Wire resolution
   // ****************************************
   // Board pull-ups hold released lines high, so no level is guessed
   assign gp_in = (~gp_oe_n & gp_out)
                | (gp_oe_n & gp_ext_en & gp_ext_val)
                | (gp_oe_n & ~gp_ext_en);
   assign hc_in = (~hc_oe_n & hc_out)
                | (hc_oe_n & hc_ext_en & hc_ext_val)
                | (hc_oe_n & ~hc_ext_en);
endmodule // gpx_pins_model

// File: testbench/gpx_top_tb_top.sv
// Bench for the GPIO port block: APB tasks and pin edge scenarios.
// Assumes the pin model above and an APB slave answering on pready.
`timescale 1ns/1ps
module gpx_top_tb_top
   import gpx_pkg::*;
;
   logic            pclk, presetn, psel, penable, pwrite;
   logic [7:0]      paddr;
   logic [31:0]     pwdata, prdata, rd;
   logic            pready, pslverr, err, gp_irq, hc_irq;
   logic [NGP-1:0]  gp_in, gp_out, gp_oe_n, gp_pu, gp_ext_en, gp_ext_val;
   logic [NHC-1:0]  hc_in, hc_out, hc_oe_n, hc_ext_en, hc_ext_val;
   logic [7:0]      dat [4];
   int              mismatches, cmp_count;

   gpx_top u_gpx_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .gp_in(gp_in),
      .gp_out(gp_out), .gp_oe_n(gp_oe_n), .gp_pu(gp_pu), .hc_in(hc_in),
      .hc_out(hc_out), .hc_oe_n(hc_oe_n), .gp_irq(gp_irq),
      .hc_irq(hc_irq));
   gpx_pins_model u_gpx_pins_model (.gp_out(gp_out), .gp_oe_n(gp_oe_n),
      .hc_out(hc_out), .hc_oe_n(hc_oe_n), .gp_ext_en(gp_ext_en),
      .gp_ext_val(gp_ext_val), .hc_ext_en(hc_ext_en),
      .hc_ext_val(hc_ext_val), .gp_in(gp_in), .hc_in(hc_in));

   always #4 pclk = ~pclk;

   // ****************************************
   // Tasks
   // ****************************************
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Counts request pulses over a window long enough for the sync path
   task automatic watch(input int eg, input int eh);
      int ng;
      int nh;
      ng = 0;
      nh = 0;
      repeat (10)
      begin
         @(posedge pclk);
         #1;
         if (gp_irq === 1'b1) ng++;
         if (hc_irq === 1'b1) nh++;
      end
      cmp_count++;
      if (ng != eg || nh != eh)
      begin
         mismatches++;
         $display("CHECK FAILED t=%0t irq %0d/%0d", $time, ng, nh);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20) mismatches++;
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Two edges per call keep pin edges far enough apart to be seen
   task automatic drv(input logic hc, input int k, input logic en,
                      input logic v);
      @(posedge pclk);
      if (hc)
      begin
         hc_ext_en[k]  <= en;
         hc_ext_val[k] <= v;
      end
      else
      begin
         gp_ext_en[k]  <= en;
         gp_ext_val[k] <= v;
      end
      @(posedge pclk);
   endtask

   task automatic settle();
      repeat (2) @(posedge pclk);
      #1;
   endtask

   task automatic do_reset();
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      settle();
   endtask

   // ****************************************
   // Sequence
   // ****************************************
   initial
   begin
      pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
      paddr = '0; pwdata = '0; gp_ext_en = '0; gp_ext_val = '0;
      hc_ext_en = '0; hc_ext_val = '0; mismatches = 0; cmp_count = 0;
      dat = '{8'hF0, 8'hFF, 8'hFF, 8'hFF};
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      settle();
      chk(gp_oe_n, 32'hFFFF_FFFF);
      chk({gp_pu[23:0], hc_oe_n}, 32'h0000_00FF);
      apb(1'b0, OFS_CFG, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h3C, 32'h0);
      chk({31'h0, err}, 32'h1);
      // Default open-drain, rising edge
      apb(1'b1, OFS_IE0, 32'h01);
      drv(0, 0, 1, 0); watch(0, 0);
      drv(0, 0, 0, 0); watch(1, 0);
      apb(1'b1, OFS_DATA0, 32'h0F);
      settle();
      chk({gp_oe_n[7:0], gp_out[7:0], gp_pu[7:0], 8'h0}, 32'h0F00_0000);
      apb(1'b1, OFS_DATA0, 32'hFF); watch(0, 0);
      // Falling edge and lockout
      apb(1'b1, OFS_CFG, 32'h01);
      drv(0, 0, 1, 0); watch(1, 0);
      apb(1'b1, OFS_IE0, 32'h03);
      drv(0, 1, 1, 0); watch(0, 0);
      drv(0, 1, 0, 0);
      drv(0, 0, 0, 0);
      drv(0, 1, 1, 0); watch(1, 0);
      apb(1'b1, OFS_IE0, 32'h01);
      drv(0, 0, 1, 0); watch(1, 0);
      drv(0, 0, 0, 0);
      drv(0, 1, 0, 0);
      apb(1'b1, OFS_CFG, 32'h11);
      apb(1'b1, OFS_IE0 + 8'h08, 32'h20);
      drv(0, 21, 1, 0); watch(1, 0);
      drv(0, 21, 0, 0); watch(0, 0);
      // Pull-up mode
      apb(1'b1, OFS_CFG, 32'h03);
      apb(1'b1, OFS_DATA0, 32'hF0);
      settle();
      chk({gp_pu[7:0], gp_oe_n[7:0], gp_out[7:0], 8'h0}, 32'hF0F0_0000);
      settle();
      apb(1'b0, OFS_DATA0, 32'h0);
      chk(rd, 32'hF0);
      apb(1'b1, OFS_IE0, 32'h80);
      drv(0, 7, 1, 0); watch(1, 0);
      drv(0, 7, 0, 0); watch(0, 0);
      // Field position of each port
      for (int p = 0; p < NPORT; p++)
      begin
         apb(1'b1, OFS_CFG, 32'h03 << (2 * p));
         settle();
         chk(gp_pu, {24'h0, dat[p]} << (8 * p));
      end
      // Driven mode
      apb(1'b1, OFS_CFG, 32'h08);
      apb(1'b1, OFS_DATA0 + 8'h04, 32'hA5);
      apb(1'b1, OFS_IE0 + 8'h04, 32'h0F);
      settle();
      chk({gp_oe_n[15:8], 4'h0, gp_out[15:12], gp_pu[15:8], 8'h0},
          32'h050A_0000);
      drv(0, 8, 1, 0); watch(0, 0);
      drv(0, 8, 0, 0); watch(0, 0);
      // High-current pins
      apb(1'b1, OFS_HC_POL, 32'h01);
      apb(1'b1, OFS_HC_IE, 32'h03);
      drv(1, 1, 1, 0); watch(0, 1);
      apb(1'b0, OFS_HC_DATA, 32'h0);
      chk(rd, 32'hFD);
      drv(1, 0, 1, 0);
      drv(1, 0, 0, 0); watch(0, 0);
      drv(1, 1, 0, 0);
      drv(1, 0, 1, 0);
      drv(1, 0, 0, 0); watch(0, 1);
      drv(1, 0, 1, 0);
      drv(1, 1, 1, 0); watch(0, 1);
      apb(1'b1, OFS_HC_IE, 32'h01);
      drv(1, 0, 0, 0); watch(0, 1);
      drv(1, 1, 0, 0);
      apb(1'b1, OFS_HC_DATA, 32'h7F);
      settle();
      chk({hc_oe_n, hc_out, 16'h0}, 32'h7F00_0000);
      settle();
      apb(1'b0, OFS_HC_DATA, 32'h0);
      chk(rd, 32'h7F);
      // Reset in mid-run restores defaults
      do_reset();
      chk({gp_pu[23:0], hc_out}, 32'h0);
      chk(gp_oe_n, 32'hFFFF_FFFF);
      drv(0, 7, 1, 0);
      drv(0, 7, 0, 0); watch(0, 0);
      end_of_test();
   end

   // Watchdog at about fourteen times the expected run
   initial
   begin
      #40000;
      mismatches++;
      end_of_test();
   end
endmodule // gpx_top_tb_top
